// file: shared/scan_pkg.sv
/*
  shared constants and carrier types for the front-end scan sequencer.
  assumes a 40 MHz system clock; all times are converted to cycles here.
*/
package scan_pkg;
  localparam int CLK_PERIOD_PS = 25000;
  // times in their own unit, figures as printed
  localparam int T_PULSE_NS = 30;
  localparam int T_SETUP_NS = 30;
  localparam int T_RS_DLY_NS = 400;
  localparam int T_WIN_DLY_NS = 30;
  localparam int T_WIN_US = 14;
  localparam int T_SS_DLY_NS = 4500;
  localparam int T_NEXT_NS = 30;
  localparam int T_HOLD_NS = 10;
  // least times round up to whole cycles
  localparam int C_PULSE = (T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_SETUP = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_RS_DLY = (T_RS_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_WIN_DLY = (T_WIN_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_WIN = (T_WIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_SS_DLY = (T_SS_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_NEXT = (T_NEXT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_HOLD = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // readout clock edges before the reset sample may follow
  localparam int READ_EDGES = 133;
  // readout clock: 40 MHz / 16 = 2.5 MHz, inside both mode limits
  localparam int RDCLK_DIV = 8;
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_SETUP = 3'b010,
    ST_READ = 3'b011,
    ST_RSAMP = 3'b100,
    ST_WIN = 3'b101,
    ST_SSAMP = 3'b110
  } scan_state_e;

  typedef struct packed {
    logic scan_start_in;
    logic integrator_reset;
    logic reset_sample_strobe;
    logic integrate_window;
    logic signal_sample_strobe;
    logic readout_clk;
  } afe_pins_s;

  typedef struct packed {
    scan_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [7:0] edges;
    logic busy;
    logic done;
    afe_pins_s pins;
  } seq_s;
endpackage

// file: core/rdclk_div.sv
/*
  divider making one-cycle enable pulses at twice the readout clock rate.
  assumes a single clock; runs only while enabled, restarts on enable low.
*/
`timescale 1ns/10ps
`default_nettype none
module rdclk_div (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  output logic tick
);
  import scan_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } div_s;
  div_s r_r, r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.tick = 1'b0;
    if (!en) begin
      r_nxt.cnt = 8'h00;
    end else if (r_r.cnt == 8'(RDCLK_DIV - 1)) begin
      r_nxt.cnt = 8'h00;
      r_nxt.tick = 1'b1;
    end else begin
      r_nxt.cnt = r_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign tick = r_r.tick;
endmodule
`default_nettype wire

// file: core/scan_seq.sv
/*
  host-side scan sequencer driving the front end's control pins.
  assumes the front end samples these pins directly; one clock, pins driven from the state register.
*/
// Notes on behaviour
// - integrator reset, sample strobes and scan start pulse high at least 30 ns.
// - scan start falls at least 30 ns before the first readout clock rise.
// - integrator reset falls at least 30 ns before the first readout clock rise.
// - reset sample rises no earlier than 400 ns after the 133rd clock rise.
// - integrate window rises at least 30 ns after reset sample rises.
// - integrate window stays high at least 14 us.
// - signal sample rises at least 4.5 us after integrate window falls.
// - integrator reset rises at least 30 ns after signal sample rises.
// - next scan start rises at least 30 ns after signal sample rises.
// - scan start falls at least 10 ns before integrator reset falls.
`timescale 1ns/10ps
`default_nettype none
module scan_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic scan_req,
  input wire logic [scan_pkg::CNT_W-1:0] win_cycles,
  output scan_pkg::afe_pins_s pins,
  output logic busy,
  output logic scan_done
);
  import scan_pkg::*;

  seq_s s_r, s_nxt;
  logic tick;
  logic [CNT_W-1:0] win_len;

  ////////////////////////////////////////////////////////////////////////
  // readout clock enable
  rdclk_div u_div (
    .clk(clk),
    .rst(rst),
    .en(s_r.state == ST_READ),
    .tick(tick)
  );

  // a short request would break the 14 us minimum, so clamp it
  assign win_len = (win_cycles < CNT_W'(C_WIN)) ? CNT_W'(C_WIN) : win_cycles;

  ////////////////////////////////////////////////////////////////////////
  // sequence
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.cnt = s_r.cnt + CNT_W'(1);
    unique case (s_r.state)
      ST_IDLE: begin
        s_nxt.cnt = '0;
        if (scan_req) begin
          s_nxt.state = ST_START;
          s_nxt.busy = 1'b1;
          s_nxt.pins.scan_start_in = 1'b1;
          s_nxt.pins.integrator_reset = 1'b1;
        end
      end
      ST_START: begin
        if (s_r.cnt == CNT_W'(C_PULSE - 1)) begin
          s_nxt.pins.scan_start_in = 1'b0;
          s_nxt.cnt = '0;
          s_nxt.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (s_r.cnt == CNT_W'(C_HOLD - 1)) begin
          s_nxt.pins.integrator_reset = 1'b0;
        end
        if (s_r.cnt == CNT_W'(C_HOLD + C_SETUP - 1)) begin
          s_nxt.cnt = '0;
          s_nxt.edges = '0;
          s_nxt.state = ST_READ;
        end
      end
      ST_READ: begin
        s_nxt.cnt = '0;
        if (tick) begin
          s_nxt.pins.readout_clk = ~s_r.pins.readout_clk;
          if (!s_r.pins.readout_clk) begin
            s_nxt.edges = s_r.edges + 8'h01;
          end else if (s_r.edges == 8'(READ_EDGES)) begin
            s_nxt.state = ST_RSAMP;
          end
        end
      end
      ST_RSAMP: begin
        if (s_r.cnt == CNT_W'(C_RS_DLY - 1)) begin
          s_nxt.pins.reset_sample_strobe = 1'b1;
        end
        if (s_r.cnt == CNT_W'(C_RS_DLY + C_PULSE - 1)) begin
          s_nxt.pins.reset_sample_strobe = 1'b0;
          s_nxt.pins.integrate_window = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.state = ST_WIN;
        end
      end
      ST_WIN: begin
        if (s_r.pins.integrate_window && s_r.cnt == win_len - CNT_W'(1)) begin
          s_nxt.pins.integrate_window = 1'b0;
          s_nxt.cnt = '0;
        end
        if (!s_r.pins.integrate_window && s_r.cnt == CNT_W'(C_SS_DLY - 1)) begin
          s_nxt.pins.signal_sample_strobe = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.state = ST_SSAMP;
        end
      end
      ST_SSAMP: begin
        if (s_r.cnt == CNT_W'(C_PULSE - 1)) begin
          s_nxt.pins.signal_sample_strobe = 1'b0;
        end
        if (s_r.cnt == CNT_W'(C_PULSE + C_NEXT - 1)) begin
          s_nxt.state = ST_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.cnt = '0;
        end
      end
      default: begin
        s_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins = s_r.pins;
  assign busy = s_r.busy;
  assign scan_done = s_r.done;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_start_width: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.scan_start_in) |=> pins.scan_start_in)
    else $error("scan start pulse too short");
  a_int_reset_width: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.integrator_reset) |=> pins.integrator_reset)
    else $error("integrator reset pulse too short");
  a_ssamp_width: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.signal_sample_strobe) |=> pins.signal_sample_strobe)
    else $error("signal sample pulse too short");
  a_rsamp_width: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.reset_sample_strobe) |=> pins.reset_sample_strobe)
    else $error("reset sample pulse too short");
  a_clk_setup: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.readout_clk) |-> !pins.integrator_reset && $past(!pins.integrator_reset, 2))
    else $error("readout clock too soon after integrator reset");
  a_start_setup: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.readout_clk) |-> !pins.scan_start_in && $past(!pins.scan_start_in, 2))
    else $error("readout clock too soon after scan start");
  a_start_hold: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.integrator_reset) |-> $past(!pins.scan_start_in))
    else $error("scan start not low before integrator reset fell");
  a_rsamp_delay: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.reset_sample_strobe) |-> $past(s_r.state == ST_RSAMP, 15) && !pins.readout_clk)
    else $error("reset sample too soon after readout");
  a_rsamp_count: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.reset_sample_strobe) |-> s_r.edges == 8'(READ_EDGES))
    else $error("reset sample before all readout edges");
  // 16 cycles from the last fall, so well past 400 ns after the last rise
  a_rsamp_exact: assert property (@(posedge clk) disable iff (rst)
    ($fell(pins.readout_clk) && s_r.state == ST_RSAMP) |->
      ##15 !pins.reset_sample_strobe ##1 pins.reset_sample_strobe)
    else $error("reset sample not 16 cycles after readout");
  a_win_after: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.integrate_window) |-> $past(pins.reset_sample_strobe, 2))
    else $error("integrate window too soon after reset sample");
  a_win_follows: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.reset_sample_strobe) |-> pins.integrate_window)
    else $error("integrate window missing after reset sample");
  a_win_min: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.integrate_window) |-> s_r.state == ST_WIN && $past(s_r.cnt) >= CNT_W'(C_WIN - 1))
    else $error("integrate window shorter than minimum");
  a_ssamp_delay: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.integrate_window) |-> !pins.signal_sample_strobe [*8])
    else $error("signal sample too soon after window");
  a_ssamp_exact: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.integrate_window) |->
      ##179 !pins.signal_sample_strobe ##1 pins.signal_sample_strobe)
    else $error("signal sample not 180 cycles after window");
  a_reset_gap: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.signal_sample_strobe) |-> !pins.integrator_reset [*3])
    else $error("integrator reset too soon after signal sample");
  a_start_order: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.scan_start_in) |-> $rose(pins.integrator_reset))
    else $error("scan start without integrator reset");
  a_start_busy: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.scan_start_in) |-> busy)
    else $error("scan started while not busy");
  // readout clock must stand still outside the readout phase
  a_clk_quiet: assert property (@(posedge clk) disable iff (rst)
    s_r.state != ST_READ |-> !pins.readout_clk)
    else $error("readout clock high outside readout");
  a_done_pulse: assert property (@(posedge clk) disable iff (rst)
    scan_done |=> !scan_done)
    else $error("scan done longer than one cycle");
  a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
    !busy |-> pins == '0)
    else $error("control pin active while idle");
  a_next_gap: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.signal_sample_strobe) |-> !pins.scan_start_in [*3])
    else $error("next scan start too soon after signal sample");
endmodule
`default_nettype wire

// file: verif/afe_model.sv
/*
  front-end device model: integrator discharge count, conversion flag,
  cascade echo and filter bandwidth. assumes pins come from the sequencer.
*/
`timescale 1ns/10ps
`default_nettype none
module afe_model #(
  parameter int ECHO_NS = 10
) (
  input wire logic rst,
  input wire scan_pkg::afe_pins_s pins,
  output var logic end_of_conv,
  output var logic scan_start_cascade_out,
  output var logic filter_bw_high,
  output var int discharge_cnt
);
  import scan_pkg::*;
  int shifts;
  always @(posedge pins.integrator_reset or posedge rst) begin
    if (rst)
      discharge_cnt <= 0;
    else
      discharge_cnt <= discharge_cnt + 1;
  end
  always @(posedge pins.readout_clk or posedge pins.scan_start_in or posedge rst) begin
    if (rst) begin
      shifts <= 0;
      end_of_conv <= 1'b1;
    end else if (pins.scan_start_in) begin
      shifts <= 0;
      end_of_conv <= 1'b0;
    end else begin
      shifts <= shifts + 1;
      end_of_conv <= (shifts + 1 >= READ_EDGES);
    end
  end
  assign #(ECHO_NS) scan_start_cascade_out = pins.scan_start_in;
  assign filter_bw_high = pins.integrate_window;
endmodule
`default_nettype wire

// file: verif/afe_scan_sequence_control_tb_top.sv
/*
  self-checking bench for the scan sequencer with a front-end model.
  assumes pin bits msb first: start, int reset, rst sample, window, sig sample, rdclk.
*/
`timescale 1ns/10ps
`default_nettype none
module afe_scan_sequence_control_tb_top;
  import scan_pkg::*;
  localparam int P = CLK_PERIOD_PS / 1000;
  logic clk = 0, rst = 1, scan_req = 0;
  logic [CNT_W-1:0] win_cycles = '0;
  afe_pins_s pins, p_q;
  logic busy, scan_done, end_of_conv, echo, bw;
  int discharges, n_errors = 0, n_tests = 0, cyc = 0, n_clk = 0, n_st = 0;
  int t_ck, t_133, clk_at_shr, t_prev;
  int rise [6], fall [6];
  initial forever #12.5 clk = ~clk;
  scan_seq dut_u (.clk(clk), .rst(rst), .scan_req(scan_req), .win_cycles(win_cycles),
    .pins(pins), .busy(busy), .scan_done(scan_done));
  afe_model model_u (.rst(rst), .pins(pins), .end_of_conv(end_of_conv),
    .scan_start_cascade_out(echo), .filter_bw_high(bw), .discharge_cnt(discharges));
  //////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    p_q <= pins;
  end
  // edges seen half a cycle after launch, stamped in cycles
  always @(negedge clk) begin
    if (pins[5] && !p_q[5]) begin
      t_prev = rise[1];
      n_clk = 0;
      n_st++;
    end
    if (pins[0] && !p_q[0]) begin
      n_clk++;
      if (n_clk == 1) t_ck = cyc;
      if (n_clk == READ_EDGES) t_133 = cyc;
    end
    if (pins[3] && !p_q[3]) clk_at_shr = n_clk;
    for (int i = 0; i < 6; i++) begin
      if (pins[i] && !p_q[i]) rise[i] = cyc;
      if (!pins[i] && p_q[i]) fall[i] = cyc;
    end
  end
  //////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check_eq(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      n_errors++;
      $display("[ERR] %0t got %0d want %0d", $time, got, exp);
    end
  endtask
  task check_ge(input int got, input int lo);
    n_tests++;
    if (got < lo) begin
      n_errors++;
      $display("[ERR] %0t got %0d below %0d", $time, got, lo);
    end
  endtask
  task check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t pin %b want %b", $time, got, exp);
    end
  endtask
  task automatic wait_done;
    int k;
    for (k = 0; k < 6000 && scan_done !== 1'b1; k++) @(posedge clk) #2;
    if (k == 6000) begin
      n_errors++;
      $display("[ERR] %0t scan end never came", $time);
      print_verdict;
    end else begin
      check_bit(busy, 1'b0);
      check_bit(|pins, 1'b0);
    end
  endtask
  task check_scan(input int win);
    check_eq(fall[5] - rise[5], 2);
    check_eq(fall[4] - rise[4], 3);
    check_eq(fall[3] - rise[3], 2);
    check_eq(fall[1] - rise[1], 2);
    check_ge((t_ck - fall[5]) * P, T_SETUP_NS);
    check_ge((t_ck - fall[4]) * P, T_SETUP_NS);
    check_eq(clk_at_shr, READ_EDGES);
    check_ge((rise[3] - t_133) * P, T_RS_DLY_NS);
    check_ge((rise[2] - rise[3]) * P, T_WIN_DLY_NS);
    check_eq(fall[2] - rise[2], win);
    check_ge((rise[1] - fall[2]) * P, T_SS_DLY_NS);
    check_ge((fall[4] - fall[5]) * P, T_HOLD_NS);
    check_eq(n_clk, READ_EDGES);
    check_eq(discharges, n_st);
    check_bit(end_of_conv, 1'b1);
    check_bit(bw, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////
  task test_clamp;
    @(posedge clk) #2 win_cycles = 16'h022f;
    scan_req = 1'b1;
    @(posedge clk) #2;
    // start has just risen; the cascade copy must still lag
    check_bit(echo, 1'b0);
    repeat (2) @(posedge clk) #2;
    check_bit(busy, 1'b1);
    check_bit(echo, 1'b1);
    scan_req = 1'b0;
    wait_done;
    check_scan(560);
    $display("test clamp done");
  endtask
  // request held high: refused while busy, then taken again at once
  task test_back_to_back;
    @(posedge clk) #2 win_cycles = 16'h0231;
    scan_req = 1'b1;
    wait_done;
    check_scan(561);
    check_eq(n_st, 2);
    repeat (8) @(posedge clk) #2;
    scan_req = 1'b0;
    check_ge((rise[4] - t_prev) * P, T_NEXT_NS);
    check_ge((rise[5] - t_prev) * P, T_NEXT_NS);
    wait_done;
    check_scan(561);
    check_eq(n_st, 3);
    $display("test back to back done");
  endtask
  task test_reset;
    repeat (16) @(posedge clk);
    check_bit(|pins, 1'b0);
    check_bit(scan_done, 1'b0);
    #2 rst = 1'b0;
    $display("test reset done");
  endtask
  initial begin
    test_reset;
    test_clamp;
    test_back_to_back;
    print_verdict;
  end
endmodule
`default_nettype wire
